// ---- input_port_defines.vh ----
// Constants for the eight-bit debounced input port
`ifndef INPUT_PORT_DEFINES_VH
`define INPUT_PORT_DEFINES_VH

// =============================================================
// Register addresses (indices on the plain register port)
`define ADDR_PORT_INPUT_VALUE    4'h0
`define ADDR_DEBOUNCE_ENABLE     4'h1
`define ADDR_EDGE_POLARITY       4'h2
`define ADDR_PULLUP_ENABLE       4'h3
`define ADDR_RESET_PATTERN_LOW   4'h4
`define ADDR_RESET_PATTERN_HIGH  4'h5
`define ADDR_SYSTEM_MISC         4'h6

// =============================================================
// Reset values
`define RST_BYTE                 8'h00

// =============================================================
// System misc control field positions
`define MISC_DEBOUNCE_FAST_BIT   0
`define MISC_RC_FROM_INPUT_BIT   1
`define MISC_WIDTH               2

// =============================================================
// Timing: clock rate and debounce sample rates
`define CLK_HZ                   100000000
`define DEB_SLOW_HZ              256
`define DEB_FAST_HZ              8000
`define DEB_SLOW_CYCLES          (`CLK_HZ / `DEB_SLOW_HZ)
`define DEB_FAST_CYCLES          (`CLK_HZ / `DEB_FAST_HZ)

`endif

// ---- input_port_debounce.v ----
// Eight-bit input port with debounce, pull-ups, edge interrupts and pattern reset
//
// Functional notes
// - Each input passes its debouncer when its enable bit is set, else raw.
// - A debounced level changes only after two equal samples on the debounce clock.
// - Debounce clock is 256 Hz with speed bit 0, 8 kHz with bit 1.
// - Debounce enable register clears to zero on configuration reset.
// - Input value register returns filtered or raw levels per bit.
// - Pull-up bit 1 connects a pull-up; bits clear on configuration reset.
// - Edge bit 0 selects rising, 1 falling; clears to rising on system reset.
// - Interrupt edges come from the debounced signal when debouncing is on.
// - Edge detection follows polarity selection; an edge-bit change can interrupt.
// - Inputs 0,1,4,5 go to the mid group, 2,3,6,7 to low, same bits.
// - Input 0 and 1 interrupts also drive events 0 and 4.
// - Inputs 0 to 3, filtered when enabled, are counter clock sources.
// - Reset request is the AND of all eight per-input reset terms.
// - Pair 00 gives 0, 01 pin, 10 inverted pin, 11 gives 1.
// - All ones in both pattern registers force the reset request.
// - Any 00 pair blocks reset; pattern registers clear on system reset.
// - RC-enable bit and input 0 high set the RC oscillator enable.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "input_port_defines.vh"

module input_port_debounce (
    // Clock and resets
    input  wire        clk,
    input  wire        rst_n,
    input  wire        pconf_rst_n,
    // Pads
    input  wire [7:0]  input_port_pin,
    output wire [7:0]  pullup_bits,
    // Register port
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // Interrupt and event outputs
    output wire [7:0]  input_interrupt_bus,
    output wire [7:0]  mid_priority_irq_group,
    output wire [7:0]  low_priority_irq_group,
    output wire [7:0]  event_flags,
    // Counter clock sources and system requests
    output wire [3:0]  counter_clock_src,
    output reg         pattern_reset_request,
    output reg         rc_oscillator_set
);

    // =============================================================
    // Configuration registers
    reg  [7:0]  debounce_enable_reg;
    reg  [7:0]  edge_polarity_reg;
    reg  [7:0]  pullup_enable_reg;
    reg  [7:0]  reset_pattern_low_reg;
    reg  [7:0]  reset_pattern_high_reg;
    reg  [1:0]  system_misc_reg;

    // Pipeline state
    reg  [7:0]  sync1_reg;
    reg  [7:0]  sync2_reg;
    reg  [7:0]  sample_reg;
    reg  [7:0]  filtered_reg;
    reg  [7:0]  polar_prev_reg;
    reg  [7:0]  irq_reg;
    reg  [19:0] div_cnt_reg;
    reg  [19:0] div_cnt_next;
    reg         deb_tick;

    wire [7:0]  input_level_bits;
    wire [7:0]  polar_level;
    wire [7:0]  per_input_reset_term;
    wire        debounce_speed_select;
    wire        rc_enable_from_input;

    assign debounce_speed_select = system_misc_reg[`MISC_DEBOUNCE_FAST_BIT];
    assign rc_enable_from_input  = system_misc_reg[`MISC_RC_FROM_INPUT_BIT];

    // =============================================================
    // Synchroniser: first stage feeds only the second
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= `RST_BYTE;
            sync2_reg <= `RST_BYTE;
        end else begin
            sync1_reg <= input_port_pin;
            sync2_reg <= sync1_reg;
        end
    end

    // =============================================================
    // Debounce clock divider, a one-cycle tick at the selected rate
    always @* begin
        div_cnt_next = div_cnt_reg + 20'h0_0001;
        deb_tick     = 1'b0;
        if (debounce_speed_select) begin
            if (div_cnt_reg >= (`DEB_FAST_CYCLES - 1)) begin
                div_cnt_next = 20'h0_0000;
                deb_tick     = 1'b1;
            end
        end else if (div_cnt_reg >= (`DEB_SLOW_CYCLES - 1)) begin
            div_cnt_next = 20'h0_0000;
            deb_tick     = 1'b1;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg <= 20'h0_0000;
        end else begin
            div_cnt_reg <= div_cnt_next;
        end
    end

    // =============================================================
    // Per-bit debouncer: accept a level seen on two successive ticks
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_deb
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sample_reg[i]   <= 1'b0;
                    filtered_reg[i] <= 1'b0;
                end else if (deb_tick) begin
                    sample_reg[i] <= sync2_reg[i];
                    if (sample_reg[i] == sync2_reg[i]) begin
                        filtered_reg[i] <= sync2_reg[i];
                    end
                end
            end
            // Raw path keeps full speed when filtering is off
            assign input_level_bits[i] = debounce_enable_reg[i] ? filtered_reg[i]
                                                                : sync2_reg[i];
            // Pattern reset term selection from the high/low pair
            assign per_input_reset_term[i] =
                (reset_pattern_high_reg[i] & reset_pattern_low_reg[i]) |
                (~reset_pattern_high_reg[i] & reset_pattern_low_reg[i] & sync2_reg[i]) |
                (reset_pattern_high_reg[i] & ~reset_pattern_low_reg[i] & ~sync2_reg[i]);
        end
    endgenerate

    // =============================================================
    // Edge detection after polarity: rising of the inverted level is a fall
    assign polar_level = input_level_bits ^ edge_polarity_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            polar_prev_reg <= `RST_BYTE;
            irq_reg        <= `RST_BYTE;
        end else begin
            polar_prev_reg <= polar_level;
            irq_reg        <= polar_level & ~polar_prev_reg;
        end
    end

    assign input_interrupt_bus    = irq_reg;
    assign mid_priority_irq_group = {2'b00, irq_reg[5:4], 2'b00, irq_reg[1:0]};
    assign low_priority_irq_group = {irq_reg[7:6], 2'b00, irq_reg[3:2], 2'b00};
    assign event_flags            = {3'b000, irq_reg[1], 3'b000, irq_reg[0]};
    assign counter_clock_src      = input_level_bits[3:0];
    assign pullup_bits            = pullup_enable_reg;

    // =============================================================
    // Pattern reset and RC enable requests, registered to avoid glitches
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pattern_reset_request <= 1'b0;
            rc_oscillator_set     <= 1'b0;
        end else begin
            pattern_reset_request <= &per_input_reset_term;
            rc_oscillator_set     <= rc_enable_from_input & input_level_bits[0];
        end
    end

    // =============================================================
    // Registers cleared by the configuration reset
    always @(posedge clk or negedge pconf_rst_n) begin
        if (!pconf_rst_n) begin
            debounce_enable_reg <= `RST_BYTE;
            pullup_enable_reg   <= `RST_BYTE;
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_DEBOUNCE_ENABLE) begin
                debounce_enable_reg <= reg_wdata;
            end
            if (reg_addr == `ADDR_PULLUP_ENABLE) begin
                pullup_enable_reg <= reg_wdata;
            end
        end
    end

    // Registers cleared by the system reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_polarity_reg      <= `RST_BYTE;
            reset_pattern_low_reg  <= `RST_BYTE;
            reset_pattern_high_reg <= `RST_BYTE;
            system_misc_reg        <= 2'b00;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_EDGE_POLARITY: begin
                    edge_polarity_reg <= reg_wdata;
                end
                `ADDR_RESET_PATTERN_LOW: begin
                    reset_pattern_low_reg <= reg_wdata;
                end
                `ADDR_RESET_PATTERN_HIGH: begin
                    reset_pattern_high_reg <= reg_wdata;
                end
                `ADDR_SYSTEM_MISC: begin
                    system_misc_reg <= reg_wdata[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // =============================================================
    // Read data stands one cycle after the strobe, zero otherwise
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_PORT_INPUT_VALUE:   reg_rdata <= input_level_bits;
                `ADDR_DEBOUNCE_ENABLE:    reg_rdata <= debounce_enable_reg;
                `ADDR_EDGE_POLARITY:      reg_rdata <= edge_polarity_reg;
                `ADDR_PULLUP_ENABLE:      reg_rdata <= pullup_enable_reg;
                `ADDR_RESET_PATTERN_LOW:  reg_rdata <= reset_pattern_low_reg;
                `ADDR_RESET_PATTERN_HIGH: reg_rdata <= reset_pattern_high_reg;
                `ADDR_SYSTEM_MISC:        reg_rdata <= {6'b00_0000, system_misc_reg};
                default:                  reg_rdata <= `RST_BYTE;
            endcase
        end else begin
            reg_rdata <= `RST_BYTE;
        end
    end

endmodule

// ---- input_port_debounce_props.sv ----
// Checker for the debounced input port, bound to its ports
`timescale 1ns/1ps
module input_port_debounce_props (
    // Clock, resets, register port, pads and counter clock sources
    input wire logic       clk, rst_n, pconf_rst_n, reg_wr, reg_rd,
    input wire logic [3:0] reg_addr, counter_clock_src,
    input wire logic [7:0] reg_wdata, reg_rdata, input_port_pin, pullup_bits,
    // Interrupts and requests
    input wire logic [7:0] input_interrupt_bus, mid_priority_irq_group,
    input wire logic [7:0] low_priority_irq_group, event_flags,
    input wire logic       pattern_reset_request, rc_oscillator_set
);
    // ==========================================================
    // Routing and pulse shape
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire [7:0] irq = input_interrupt_bus;
    a_mid_map: assert property (mid_priority_irq_group == (irq & 8'h33))
        else $error("mid group routing wrong");
    a_low_map: assert property (low_priority_irq_group == (irq & 8'hcc))
        else $error("low group routing wrong");
    a_evt_map: assert property (event_flags == {3'h0, irq[1], 3'h0, irq[0]})
        else $error("event routing wrong");
    a_irq_pulse: assert property ((irq & $past(irq)) == 8'h00)
        else $error("interrupt held two cycles");
    // ==========================================================
    // Register port; a write followed at once by a read returns the byte
    property wr_rd(logic [3:0] a);
        (reg_wr && reg_addr == a) ##1 (reg_rd && reg_addr == a)
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    // Software reset: both pattern bytes all ones, idle cycle between the writes
    property sw_rst;
        (reg_wr && reg_addr == 4'h4 && reg_wdata == 8'hff) ##1 !reg_wr
            ##1 (reg_wr && reg_addr == 4'h5 && reg_wdata == 8'hff)
            |-> ##[1:3] pattern_reset_request;
    endproperty
    a_rd_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
        else $error("read data without a read");
    a_pullup_clr: assert property (!pconf_rst_n |-> pullup_bits == 8'h00)
        else $error("pull-ups not cleared");
    a_edge_rdbk: assert property (wr_rd(4'h2))
        else $error("edge select readback wrong");
    a_pat_rdbk: assert property (wr_rd(4'h5))
        else $error("pattern readback wrong");
    a_sw_reset: assert property (sw_rst)
        else $error("software reset not requested");
    c_irq: cover property (irq != 8'h00);
    c_req: cover property ($rose(pattern_reset_request));
    c_rc: cover property (rc_oscillator_set);
endmodule
bind input_port_debounce input_port_debounce_props props_i (.clk, .rst_n, .pconf_rst_n,
    .reg_wr, .reg_rd, .reg_addr, .counter_clock_src, .reg_wdata, .reg_rdata, .input_port_pin,
    .pullup_bits, .input_interrupt_bus, .mid_priority_irq_group, .low_priority_irq_group,
    .event_flags, .pattern_reset_request, .rc_oscillator_set);

// ---- pad_source.sv ----
// Model of the external signals on the eight input pads
`timescale 1ns/1ps
module pad_source (
    // Requested levels and which pads are driven
    input  wire logic [7:0] drv_val,
    input  wire logic [7:0] drv_oe,
    // Pull-up control from the port
    input  wire logic [7:0] pullup_bits,
    output wire logic [7:0] pin
);
    // Undriven pads follow the pull-up, else drift away from the last level
    assign pin = (drv_oe & drv_val) | (~drv_oe & (pullup_bits | ~drv_val));
endmodule

// ---- input_port_debounce_tb_top.sv ----
// Self-checking bench for the debounced input port
`timescale 1ns/1ps
module input_port_debounce_tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, pconf_rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  drv_val = 8'h00, drv_oe = 8'hff, reg_wdata = 8'h00, seen, p, np, e, ne, lo, hi;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] rnd = 32'h0000_9f8c;
    wire  [7:0]  pin, pullup_bits, reg_rdata, irq, mid, low, evt;
    wire  [3:0]  cnt_src;
    wire         req, rc_set;
    int          err_count = 0, compares = 0, i;

    // ==========================================================
    // Clock, pads and design
    initial forever #5 clk = ~clk;
    pad_source pads (.drv_val(drv_val), .drv_oe(drv_oe), .pullup_bits(pullup_bits), .pin(pin));
    input_port_debounce dut (.clk(clk), .rst_n(rst_n), .pconf_rst_n(pconf_rst_n),
        .input_port_pin(pin), .pullup_bits(pullup_bits), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .input_interrupt_bus(irq), .mid_priority_irq_group(mid), .low_priority_irq_group(low),
        .event_flags(evt), .counter_clock_src(cnt_src), .pattern_reset_request(req),
        .rc_oscillator_set(rc_set));

    // ==========================================================
    // Helpers; every task except chk and results is entered and left just after a rising edge
    function automatic logic [7:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd[7:0];
    endfunction
    function automatic logic want_req(input logic [7:0] l, h, pv);
        return &((l & h) | (l & ~h & pv) | (~l & h & ~pv));
    endfunction
    task automatic chk(input logic [7:0] got, exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
        end
    endtask
    // A strobe still pending low waits one edge, so it is never set twice at once
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        if (reg_wr) @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, exp);
        @(posedge clk);
    endtask
    // Interrupt pulses last one cycle, so gather them mid-cycle
    task automatic run(input int n);
        seen = 8'h00;
        repeat (n) begin
            @(negedge clk);
            seen = seen | irq;
        end
        @(posedge clk);
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==========================================================
    // Watchdog: the run needs about 25400 cycles, so allow under twice that
    initial begin
        #500_000;
        err_count++;
        results();
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        pconf_rst_n <= 1'b1;
        @(posedge clk);
        for (i = 1; i < 7; i++) rd(i[3:0], 8'h00);
        rd(4'hf, 8'h00);
        p = xs();
        wr(4'h3, p);
        rd(4'h3, p);
        chk(pullup_bits, p);
        wr(4'h1, ~p);
        pconf_rst_n <= 1'b0;
        @(posedge clk);
        pconf_rst_n <= 1'b1;
        rd(4'h1, 8'h00);
        rd(4'h3, 8'h00);
        wr(4'h3, 8'hff);
        drv_oe <= 8'h00;
        run(4);
        rd(4'h0, 8'hff);
        drv_oe <= 8'hff;
        run(4);
        // Raw edges under random polarity, including the polarity write itself
        p = 8'h00;
        e = 8'h00;
        for (i = 0; i < 10; i++) begin
            ne = xs();
            np = xs();
            wr(4'h2, ne);
            run(4);
            chk(seen, ~(p ^ e) & (p ^ ne));
            e = ne;
            drv_val <= np;
            run(5);
            chk(seen, ~(p ^ e) & (np ^ e));
            rd(4'h0, np);
            chk({4'h0, cnt_src}, {4'h0, np[3:0]});
            p = np;
        end
        // Rewriting the same polarity must not disturb it, and reads back at once
        wr(4'h2, e);
        rd(4'h2, e);
        // Pattern reset; the high byte is cleared first to block stray resets
        for (i = 0; i < 8; i++) begin
            lo = (i == 0) ? 8'hff : xs();
            hi = (i == 0) ? 8'hff : xs();
            if (i[0]) lo = lo | p;
            if (i[0]) hi = hi | ~p;
            wr(4'h5, 8'h00);
            wr(4'h4, lo);
            wr(4'h5, hi);
            rd(4'h5, hi);
            run(3);
            chk({7'h0, req}, {7'h0, want_req(lo, hi, p)});
        end
        wr(4'h4, 8'h00);
        wr(4'h6, 8'h02);
        drv_val <= 8'h01;
        run(4);
        chk({7'h0, rc_set}, 8'h01);
        drv_val <= 8'h00;
        run(4);
        chk({7'h0, rc_set}, 8'h00);
        // Debounced input 0 on the fast clock: held off for at least 20 cycles
        wr(4'h2, 8'h00);
        wr(4'h6, 8'h01);
        wr(4'h1, 8'h01);
        drv_val <= 8'h01;
        run(20);
        chk(seen, 8'h00);
        rd(4'h0, 8'h00);
        run(25100);
        chk(seen, 8'h01);
        rd(4'h0, 8'h01);
        results();
    end
endmodule
